// ===== rtl/i2c_master_slave_status_ctrl.sv
// Notes on behaviour
// - acknowledge sequence sends NACK when ack value is one, ACK when zero
// - ack trigger runs one acknowledge bit; hardware clears it at the end
// - receive trigger clocks in one byte; cleared after the eighth bit
// - stop trigger makes a stop condition; cleared when it completes
// - restart trigger makes a repeated start; cleared when it completes
// - start trigger makes a start condition; cleared when it completes
// - ack received status takes the slave acknowledge bit in master transmit
// - transmit active set when master byte starts, cleared after slave ack
// - bus collision during master start or transmit sets a sticky flag
// - general call seen set on general call address, cleared at stop
// - ten bit match set on matching second address byte, cleared at stop
// - transmit write while busy is dropped and sets write collision
// - byte completing while receive buffer full sets overflow
// - data flag cleared on address match, set on data byte received as slave
// - start and stop seen flags show which condition came last
// - slave records read or write direction from address byte
// - receive full set on buffer load, cleared by software read
// - transmit full set by software write, cleared when data sent
// - mask bit one makes that address bit a don't care
// - receiver is double buffered and pulses an event on each load
// - mode bit selects ten or seven bit own address compare
// - general call pulses an event when enabled, ignored when disabled
`timescale 1ns/1ps
`default_nettype none
module i2c_master_slave_status_ctrl #(
   parameter int QUARTER_CYCLES = i2c_pkg::QUARTER_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [i2c_pkg::ADDR_W-1:0] addr,
   input wire logic [i2c_pkg::DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [i2c_pkg::DATA_W-1:0] rdata,
   input wire logic serial_clock_line_i,
   output logic serial_clock_line_o,
   output logic serial_clock_line_oe_n,
   input wire logic serial_data_line_i,
   output logic serial_data_line_o,
   output logic serial_data_line_oe_n,
   output logic rx_event,
   output logic general_call_event
);
   import i2c_pkg::*;

   ctrl_t ctrl;
   ctrl_t next_ctrl;
   status_t st;
   status_t next_st;
   status_t wst;
   logic [15:0] address_bit_mask;
   logic [15:0] own_slave_address;
   logic [7:0] tx_holding_register;
   logic [7:0] rx_holding_register;
   mstate_t mstate;
   sstate_t sstate;
   logic [1:0] q;
   logic [3:0] mbit;
   logic [7:0] mshift;
   logic [7:0] mrx;
   logic owns;
   logic [15:0] tick_cnt;
   logic [7:0] rx_shift_register;
   logic [7:0] s_tx;
   logic [3:0] s_cnt;
   logic s_ack;
   logic s_sda_low;

   ////////////////////////////////////////////////////////////////////////////
   // line synchronisers, one per bus wire
   logic [1:0] line_raw;
   logic [1:0] line_lvl;
   logic [1:0] line_rise;
   logic [1:0] line_fall;
   assign line_raw = {serial_data_line_i, serial_clock_line_i};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_sync
         line_sync u_sync (
            .ref_clk(ref_clk),
            .rst(rst),
            .raw(line_raw[gi]),
            .level(line_lvl[gi]),
            .rise(line_rise[gi]),
            .fall(line_fall[gi])
         );
      end
   endgenerate

   wire scl_s = line_lvl[0];
   wire scl_rise = line_rise[0];
   wire scl_fall = line_fall[0];
   wire sda_s = line_lvl[1];
   wire start_det = line_fall[1] & scl_s;
   wire stop_det = line_rise[1] & scl_s;

   ////////////////////////////////////////////////////////////////////////////
   // register port decode
   wire wr_ctrl = wr & (addr == OFS_BUS_CONTROL);
   wire wr_stat = wr & (addr == OFS_BUS_STATUS);
   wire wr_mask = wr & (addr == OFS_SLAVE_ADDRESS_MASK);
   wire wr_tx = wr & (addr == OFS_TX_HOLDING);
   wire wr_own = wr & (addr == OFS_OWN_SLAVE_ADDRESS);
   wire rd_rx = rd & (addr == OFS_RX_HOLDING);
   assign wst = status_t'(wdata);

   // unmapped offsets read as zero
   wire [15:0] rd_mux = (addr == OFS_BUS_CONTROL) ? 16'(ctrl) :
                        (addr == OFS_BUS_STATUS) ? 16'(st) :
                        (addr == OFS_SLAVE_ADDRESS_MASK) ? address_bit_mask :
                        (addr == OFS_TX_HOLDING) ? {8'h00, tx_holding_register} :
                        (addr == OFS_RX_HOLDING) ? {8'h00, rx_holding_register} :
                        (addr == OFS_OWN_SLAVE_ADDRESS) ? own_slave_address : 16'h0000;

   ////////////////////////////////////////////////////////////////////////////
   // quarter-bit enable from the clock divider
   wire tick = (tick_cnt == 16'(QUARTER_CYCLES - 1));

   always_ff @(posedge ref_clk) begin
      if (rst || tick) begin
         tick_cnt <= 16'h0000;
      end else begin
         tick_cnt <= tick_cnt + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // master sequencer decode
   wire st_idle = (mstate == M_IDLE);
   wire st_start = (mstate == M_START);
   wire st_restart = (mstate == M_RESTART);
   wire st_stop = (mstate == M_STOP);
   wire st_tx = (mstate == M_TX);
   wire st_rx = (mstate == M_RX);
   wire st_ack = (mstate == M_ACK);
   wire st_bit = st_tx | st_rx | st_ack;
   wire any_trig = ctrl.start_trigger | ctrl.restart_trigger | ctrl.stop_trigger |
                   ctrl.master_receive_trigger | ctrl.ack_sequence_trigger;
   wire m_go_tx = st_idle & owns & st.tx_buffer_full & ~any_trig;

   // slave may stretch scl: the high phase waits until the wire is seen high
   wire m_adv = tick & ~st_idle & (~st_bit | (q != 2'd2) | scl_s);
   wire m_sample = m_adv & st_bit & (q == 2'd2);
   wire last_q = (st_start | st_stop) ? (q == 2'd2) : (q == 2'd3);
   wire bit_last = st_tx ? (mbit == 4'd8) : (st_rx ? (mbit == 4'd7) : 1'b1);
   wire m_done = m_adv & last_q & bit_last;
   wire tx_data_bit = (mbit < 4'd8);
   wire m_coll = (m_sample & st_tx & tx_data_bit & mshift[7] & ~sda_s) |
                 (m_adv & st_start & (q == 2'd0) & ~(sda_s & scl_s));

   // line drive, one term per sequence
   wire m_scl_low = (st_idle & owns) | (st_start & (q == 2'd2)) |
                    ((st_restart | st_bit) & ((q == 2'd0) | (q == 2'd3))) |
                    (st_stop & (q == 2'd0));
   wire m_sda_low = (st_start & (q != 2'd0)) |
                    (st_restart & q[1]) |
                    (st_stop & ~q[1]) |
                    (st_tx & tx_data_bit & ~mshift[7]) |
                    (st_ack & ~ctrl.ack_value_select);

   // master state, bit and shift registers
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         mstate <= M_IDLE;
         q <= 2'd0;
         mbit <= 4'd0;
         mshift <= 8'h00;
         mrx <= 8'h00;
         owns <= 1'b0;
      end else if (m_coll) begin
         // losing arbitration drops the bus at once
         mstate <= M_IDLE;
         q <= 2'd0;
         mbit <= 4'd0;
         owns <= 1'b0;
      end else if (st_idle) begin
         q <= 2'd0;
         mbit <= 4'd0;
         if (ctrl.start_trigger) begin
            mstate <= M_START;
         end else if (ctrl.restart_trigger) begin
            mstate <= M_RESTART;
         end else if (ctrl.stop_trigger) begin
            mstate <= M_STOP;
         end else if (ctrl.master_receive_trigger) begin
            mstate <= M_RX;
         end else if (ctrl.ack_sequence_trigger) begin
            mstate <= M_ACK;
         end else if (m_go_tx) begin
            mstate <= M_TX;
            mshift <= tx_holding_register;
         end
      end else if (m_adv) begin
         if (m_sample && st_rx) begin
            mrx <= {mrx[6:0], sda_s};
         end
         if (!last_q) begin
            q <= q + 2'd1;
         end else if (bit_last) begin
            q <= 2'd0;
            mstate <= M_IDLE;
            owns <= (st_start | st_restart) ? 1'b1 : (st_stop ? 1'b0 : owns);
         end else begin
            q <= 2'd0;
            mbit <= mbit + 4'd1;
            mshift <= {mshift[6:0], 1'b0};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // slave address compare; masked positions never mismatch
   wire [7:0] s_byte = {rx_shift_register[6:0], sda_s};
   wire s_on = (sstate != S_IDLE) & ~owns;
   wire s_byte_end = s_on & scl_rise & (s_cnt == 4'd7);
   wire gc_hit = ctrl.general_call_enable & (s_byte == GENERAL_CALL_ADDR);
   wire m7 = ~ctrl.ten_bit_slave_mode &
             (((s_byte[7:1] ^ own_slave_address[6:0]) & ~address_bit_mask[6:0]) == 7'h00);
   wire hi10 = ctrl.ten_bit_slave_mode & (s_byte[7:3] == TEN_BIT_PREFIX) &
               (((s_byte[2:1] ^ own_slave_address[9:8]) & ~address_bit_mask[9:8]) == 2'b00);
   wire lo10 = (((s_byte ^ own_slave_address[7:0]) & ~address_bit_mask[7:0]) == 8'h00);
   wire a_rd = (m7 & s_byte[0]) | (hi10 & s_byte[0] & st.ten_bit_match_flag);
   wire a_wr = gc_hit | (m7 & ~s_byte[0]) | (hi10 & ~s_byte[0]);
   wire in_a1 = (sstate == S_ADDR1);
   wire in_a2 = (sstate == S_ADDR2);
   wire in_srx = (sstate == S_RX);
   wire in_stx = (sstate == S_TX);
   wire s_match = s_byte_end & ((in_a1 & (a_rd | a_wr)) | (in_a2 & lo10));
   wire s_gc_ev = s_byte_end & in_a1 & gc_hit;
   wire s_ten_bit_match_flag_ev = s_byte_end & in_a2 & lo10;
   wire s_data_ev = s_byte_end & in_srx;
   wire s_tx_sent = s_byte_end & in_stx;
   wire [2:0] s_idx = 3'd7 - s_cnt[2:0];

   // slave bit engine on synchronised scl edges
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sstate <= S_IDLE;
         s_cnt <= 4'd0;
         rx_shift_register <= 8'h00;
         s_tx <= 8'h00;
         s_ack <= 1'b0;
         s_sda_low <= 1'b0;
      end else if (start_det) begin
         sstate <= S_ADDR1;
         s_cnt <= 4'd0;
         s_sda_low <= 1'b0;
      end else if (stop_det || !s_on) begin
         sstate <= stop_det ? S_IDLE : sstate;
         s_sda_low <= 1'b0;
      end else if (scl_rise) begin
         if (s_cnt == 4'd8) begin
            // ack slot: a master nack ends a slave read
            s_cnt <= 4'd0;
            s_ack <= 1'b0;
            if (in_stx && sda_s) begin
               sstate <= S_IDLE;
            end else if (in_stx) begin
               s_tx <= tx_holding_register;
            end
         end else begin
            rx_shift_register <= s_byte;
            s_cnt <= s_cnt + 4'd1;
         end
         if (s_byte_end) begin
            s_ack <= s_match | in_srx;
            if (in_a1 && a_rd) begin
               sstate <= S_TX;
               s_tx <= tx_holding_register;
            end else if (in_a1 && hi10 && !s_byte[0]) begin
               sstate <= S_ADDR2;
            end else if ((in_a1 && a_wr) || (in_a2 && lo10)) begin
               sstate <= S_RX;
            end else if (!in_srx && !in_stx) begin
               sstate <= S_IDLE;
            end
         end
      end else if (scl_fall) begin
         // change sda only while scl is low
         s_sda_low <= (in_stx && s_cnt < 4'd8) ? ~s_tx[s_idx] : ((s_cnt == 4'd8) & s_ack);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // receive buffer load, shared by master receive and slave
   wire m_rx_load = m_done & st_rx;
   wire rx_load = m_rx_load | s_match | s_data_ev;
   wire [7:0] rx_data = m_rx_load ? mrx : s_byte;
   wire rx_ok = rx_load & ~st.rx_buffer_full;
   wire tx_busy = ~st_idle | st.tx_buffer_full;
   wire tx_ok = wr_tx & ~tx_busy;

   // hardware clears triggers at the end of their own sequence
   always_comb begin
      next_ctrl = wr_ctrl ? ctrl_t'(wdata & CTRL_WMASK) : ctrl;
      if (m_coll) begin
         next_ctrl.start_trigger = 1'b0;
         next_ctrl.restart_trigger = 1'b0;
         next_ctrl.stop_trigger = 1'b0;
         next_ctrl.master_receive_trigger = 1'b0;
         next_ctrl.ack_sequence_trigger = 1'b0;
      end
      if (m_done && st_start) next_ctrl.start_trigger = 1'b0;
      if (m_done && st_restart) next_ctrl.restart_trigger = 1'b0;
      if (m_done && st_stop) next_ctrl.stop_trigger = 1'b0;
      if (m_done && st_rx) next_ctrl.master_receive_trigger = 1'b0;
      if (m_done && st_ack) next_ctrl.ack_sequence_trigger = 1'b0;
   end

   // status flags; hardware sets win over a same-cycle software clear
   always_comb begin
      next_st = st;
      next_st.rsv13_11 = 3'b000;
      if (m_sample && st_tx && !tx_data_bit) next_st.ack_received_status = sda_s;
      next_st.master_tx_active = (st_idle & m_go_tx) |
                                 (st.master_tx_active & ~(m_done & st_tx) & ~m_coll);
      next_st.bus_collision_flag = m_coll |
         (st.bus_collision_flag & ~(wr_stat & ~wst.bus_collision_flag));
      next_st.general_call_seen = s_gc_ev | (st.general_call_seen & ~stop_det);
      next_st.ten_bit_match_flag = s_ten_bit_match_flag_ev | (st.ten_bit_match_flag & ~stop_det);
      next_st.tx_write_collision = (wr_tx & tx_busy) |
         (st.tx_write_collision & ~(wr_stat & ~wst.tx_write_collision));
      next_st.rx_overflow_flag = (rx_load & st.rx_buffer_full) |
         (st.rx_overflow_flag & ~(wr_stat & ~wst.rx_overflow_flag));
      if (s_match) next_st.data_not_address = 1'b0;
      if (s_data_ev) next_st.data_not_address = 1'b1;
      if (start_det) begin
         next_st.start_seen = 1'b1;
         next_st.stop_seen = 1'b0;
      end else if (stop_det) begin
         next_st.start_seen = 1'b0;
         next_st.stop_seen = 1'b1;
      end
      if (s_match) next_st.read_not_write = in_a1 & a_rd;
      next_st.rx_buffer_full = rx_ok | (st.rx_buffer_full & ~rd_rx);
      next_st.tx_buffer_full = tx_ok |
         (st.tx_buffer_full & ~((m_done & st_tx) | s_tx_sent | m_coll));
   end

   ////////////////////////////////////////////////////////////////////////////
   // register storage
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl <= ctrl_t'(CTRL_RESET);
         st <= status_t'(STATUS_RESET);
         address_bit_mask <= MASK_RESET;
         own_slave_address <= OWN_RESET;
         tx_holding_register <= 8'h00;
         rx_holding_register <= 8'h00;
      end else begin
         ctrl <= next_ctrl;
         st <= next_st;
         if (wr_mask) address_bit_mask <= wdata & MASK_WMASK;
         if (wr_own) own_slave_address <= wdata & OWN_WMASK;
         if (tx_ok) tx_holding_register <= wdata[7:0];
         if (rx_ok) rx_holding_register <= rx_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registered outputs; open-drain pins only ever pull low
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata <= 16'h0000;
         serial_clock_line_o <= 1'b0;
         serial_clock_line_oe_n <= 1'b1;
         serial_data_line_o <= 1'b0;
         serial_data_line_oe_n <= 1'b1;
         rx_event <= 1'b0;
         general_call_event <= 1'b0;
      end else begin
         rdata <= rd ? rd_mux : 16'h0000;
         serial_clock_line_o <= 1'b0;
         serial_clock_line_oe_n <= ~m_scl_low;
         serial_data_line_o <= 1'b0;
         serial_data_line_oe_n <= ~(m_sda_low | s_sda_low);
         rx_event <= rx_load;
         general_call_event <= s_gc_ev;
      end
   end
endmodule : i2c_master_slave_status_ctrl
`default_nettype wire

// ===== rtl/i2c_pkg.sv
package i2c_pkg;
   // register port geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;

   // register offsets on the plain register port
   localparam logic [3:0] OFS_BUS_CONTROL = 4'h0;
   localparam logic [3:0] OFS_BUS_STATUS = 4'h1;
   localparam logic [3:0] OFS_SLAVE_ADDRESS_MASK = 4'h2;
   localparam logic [3:0] OFS_TX_HOLDING = 4'h3;
   localparam logic [3:0] OFS_RX_HOLDING = 4'h4;
   localparam logic [3:0] OFS_OWN_SLAVE_ADDRESS = 4'h5;

   // writable bits and reset values
   localparam logic [15:0] CTRL_WMASK = 16'h04BF;
   localparam logic [15:0] MASK_WMASK = 16'h03FF;
   localparam logic [15:0] OWN_WMASK = 16'h03FF;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [15:0] MASK_RESET = 16'h0000;
   localparam logic [15:0] OWN_RESET = 16'h0000;

   // address byte patterns
   localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;
   localparam logic [7:0] GENERAL_CALL_ADDR = 8'h00;

   // timing: one scl bit is four quarter phases
   localparam int CLK_PERIOD_NS = 20;
   localparam int SCL_BIT_NS = 10000;
   localparam int QUARTER_CYCLES = SCL_BIT_NS / (4 * CLK_PERIOD_NS);

   // control register layout
   typedef struct packed {
      logic [4:0] rsv15_11;
      logic ten_bit_slave_mode;
      logic [1:0] rsv9_8;
      logic general_call_enable;
      logic rsv6;
      logic ack_value_select;
      logic ack_sequence_trigger;
      logic master_receive_trigger;
      logic stop_trigger;
      logic restart_trigger;
      logic start_trigger;
   } ctrl_t;

   // status register layout
   typedef struct packed {
      logic ack_received_status;
      logic master_tx_active;
      logic [2:0] rsv13_11;
      logic bus_collision_flag;
      logic general_call_seen;
      logic ten_bit_match_flag;
      logic tx_write_collision;
      logic rx_overflow_flag;
      logic data_not_address;
      logic stop_seen;
      logic start_seen;
      logic read_not_write;
      logic rx_buffer_full;
      logic tx_buffer_full;
   } status_t;

   // master sequencer states
   typedef enum logic [6:0] {
      M_IDLE = 7'b0000001,
      M_START = 7'b0000010,
      M_RESTART = 7'b0000100,
      M_STOP = 7'b0001000,
      M_TX = 7'b0010000,
      M_RX = 7'b0100000,
      M_ACK = 7'b1000000
   } mstate_t;

   // slave receive and transmit states
   typedef enum logic [4:0] {
      S_IDLE = 5'b00001,
      S_ADDR1 = 5'b00010,
      S_ADDR2 = 5'b00100,
      S_RX = 5'b01000,
      S_TX = 5'b10000
   } sstate_t;
endpackage : i2c_pkg

// ===== rtl/line_sync.sv
`timescale 1ns/1ps
`default_nettype none
module line_sync (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic raw,
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta;
   logic stable;
   logic prev;

   // two flops before use; idle bus level is high
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         meta <= 1'b1;
         stable <= 1'b1;
         prev <= 1'b1;
      end else begin
         meta <= raw;
         stable <= meta;
         prev <= stable;
      end
   end

   // edges only look at the settled copies
   assign level = stable;
   assign rise = stable & ~prev;
   assign fall = ~stable & prev;
endmodule : line_sync
`default_nettype wire

// ===== testbench/i2c_bus_partner.sv
`timescale 1ns/1ps
`default_nettype none
// far-side slave: acks or nacks written bytes, shifts a byte out when asked
module i2c_bus_partner (
   input wire logic scl,
   input wire logic sda,
   input wire logic send,
   input wire logic ack_low,
   input wire logic [7:0] byte_out,
   output logic sda_oe_n,
   output logic last_bit
);
   int bitn = 0;
   initial sda_oe_n = 1'b1;
   // start or repeated start restarts the bit count
   always @(negedge sda) if (scl) bitn = 0;
   // last_bit lets the bench see what the master put on the wire
   always @(posedge scl) begin
      last_bit = sda;
      bitn = (bitn == 8) ? 0 : bitn + 1;
   end
   // sda only moves while scl is low; a released line reads high by pull-up
   always @(negedge scl, send) begin
      if (!scl) sda_oe_n = send ? (bitn == 8 || byte_out[7 - bitn]) : !(bitn == 8 && ack_low);
   end
endmodule : i2c_bus_partner
`default_nettype wire

// ===== testbench/i2c_status_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_status_ctrl_sva (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [i2c_pkg::ADDR_W-1:0] addr,
   input wire logic [i2c_pkg::DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [i2c_pkg::DATA_W-1:0] rdata,
   input wire logic rx_event,
   input wire logic general_call_event
);
   import i2c_pkg::*;
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   // one read request of a given offset
   sequence read_of(logic [3:0] o);
      rd && addr == o;
   endsequence
   // mask write, idle cycle, mask read, as the bench tasks issue them
   sequence mask_wr_rd;
      wr && addr == OFS_SLAVE_ADDRESS_MASK ##2 read_of(OFS_SLAVE_ADDRESS_MASK);
   endsequence
   rdata_idle_a: assert property (!$past(rd) |-> rdata == 16'h0000)
      else $error("read data not zero outside answer cycle");
   unmapped_read_a: assert property (rd && addr > OFS_OWN_SLAVE_ADDRESS |=> rdata == 16'h0000)
      else $error("unmapped read not zero");
   status_rsv_a: assert property (read_of(OFS_BUS_STATUS) |=> rdata[13:11] == 3'h0)
      else $error("status reserved bits not zero");
   mask_rsv_a: assert property (read_of(OFS_SLAVE_ADDRESS_MASK) |=> rdata[15:10] == 6'h00)
      else $error("mask reserved bits not zero");
   ctrl_rsv_a: assert property (read_of(OFS_BUS_CONTROL) |=> (rdata & ~CTRL_WMASK) == 16'h0000)
      else $error("control unused bits not zero");
   mask_value_a: assert property (mask_wr_rd |=> rdata == ($past(wdata, 3) & MASK_WMASK))
      else $error("mask read back wrong");
   rx_pulse_a: assert property (rx_event |=> !rx_event)
      else $error("rx event longer than one cycle");
   gc_pulse_a: assert property (general_call_event |=> !general_call_event)
      else $error("general call event longer than one cycle");
endmodule : i2c_status_ctrl_sva
bind i2c_master_slave_status_ctrl i2c_status_ctrl_sva u_i2c_status_ctrl_sva (
   .ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .rx_event(rx_event), .general_call_event(general_call_event));
`default_nettype wire

// ===== testbench/tb_i2c_master_slave_status_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_master_slave_status_ctrl;
   import i2c_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic send = 1'b0;
   logic jam = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic [15:0] rdata, d;
   logic scl_oe_n, sda_oe_n, part_oe_n, last_bit, rx_event, gc_event;
   // open-drain wires with pull-up; jam stands for a rival master holding sda
   wire scl_w = scl_oe_n;
   wire sda_w = sda_oe_n & part_oe_n & !jam;
   int err_total = 0;
   int checked = 0;
   always #10 ref_clk = ~ref_clk;
   // event pulses counted on the edge that samples them
   logic [15:0] rx_cnt = 16'h0000;
   logic [15:0] gc_cnt = 16'h0000;
   always @(posedge ref_clk) begin
      if (rx_event) rx_cnt <= rx_cnt + 16'h0001;
      if (gc_event) gc_cnt <= gc_cnt + 16'h0001;
   end
   i2c_master_slave_status_ctrl #(.QUARTER_CYCLES(4)) u_i2c_master_slave_status_ctrl (
      .ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .serial_clock_line_i(scl_w), .serial_clock_line_o(),
      .serial_clock_line_oe_n(scl_oe_n), .serial_data_line_i(sda_w), .serial_data_line_o(),
      .serial_data_line_oe_n(sda_oe_n), .rx_event(rx_event), .general_call_event(gc_event));
   i2c_bus_partner u_i2c_bus_partner (.scl(scl_w), .sda(sda_w), .send(send), .ack_low(1'b0),
      .byte_out(8'hC3), .sda_oe_n(part_oe_n), .last_bit(last_bit));
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
      @(posedge ref_clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask : wr_reg
   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a);
      @(posedge ref_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      @(negedge ref_clk);
      d = rdata;
   endtask : rd_reg
   task automatic chk(input logic [15:0] m, input logic [15:0] e);
      checked++;
      if ((d & m) !== e) begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, d & m, e);
      end
   endtask : chk
   // polls until the bits fall; a hang shows up as one counted error
   task automatic wait_clr(input logic [3:0] a, input logic [15:0] m);
      for (int i = 0; i < 500; i++) begin
         rd_reg(a);
         if ((d & m) === 16'h0000) return;
      end
      err_total++;
   endtask : wait_clr
   task automatic end_of_test;
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test
   initial begin
      #200000;
      err_total++;
      end_of_test();
   end
   // master sequences in order: collision, start, transmit, receive, nack, receive, ack, restart, stop
   initial begin
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      rd_reg(OFS_BUS_STATUS);
      chk(16'hFFFF, STATUS_RESET);
      wr_reg(OFS_SLAVE_ADDRESS_MASK, 16'hFFFF);
      rd_reg(OFS_SLAVE_ADDRESS_MASK);
      chk(16'hFFFF, 16'h03FF);
      rd_reg(4'hF);
      chk(16'hFFFF, 16'h0000);
      @(posedge ref_clk);
      jam <= 1'b1;
      wr_reg(OFS_BUS_CONTROL, 16'h0001);
      wait_clr(OFS_BUS_CONTROL, 16'h0001);
      rd_reg(OFS_BUS_STATUS);
      chk(16'h0400, 16'h0400);
      @(posedge ref_clk);
      jam <= 1'b0;
      wr_reg(OFS_BUS_STATUS, 16'h0000);
      rd_reg(OFS_BUS_STATUS);
      chk(16'h0400, 16'h0000);
      wr_reg(OFS_BUS_CONTROL, 16'h0001);
      wait_clr(OFS_BUS_CONTROL, 16'h0001);
      rd_reg(OFS_BUS_STATUS);
      chk(16'h0018, 16'h0008);
      wr_reg(OFS_TX_HOLDING, 16'h00A6);
      wr_reg(OFS_TX_HOLDING, 16'h0055);
      rd_reg(OFS_BUS_STATUS);
      chk(16'h4081, 16'h4081);
      wait_clr(OFS_BUS_STATUS, 16'h4001);
      chk(16'hC081, 16'h8080);
      @(posedge ref_clk);
      send <= 1'b1;
      wr_reg(OFS_BUS_STATUS, 16'h0000);
      wr_reg(OFS_BUS_CONTROL, 16'h0028);
      wait_clr(OFS_BUS_CONTROL, 16'h0008);
      rd_reg(OFS_BUS_STATUS);
      chk(16'h00C2, 16'h0002);
      wr_reg(OFS_BUS_CONTROL, 16'h0030);
      wait_clr(OFS_BUS_CONTROL, 16'h0010);
      d = {15'h0000, last_bit};
      chk(16'h0001, 16'h0001);
      wr_reg(OFS_BUS_CONTROL, 16'h0008);
      wait_clr(OFS_BUS_CONTROL, 16'h0008);
      @(posedge ref_clk);
      send <= 1'b0;
      rd_reg(OFS_BUS_STATUS);
      chk(16'h0042, 16'h0042);
      wr_reg(OFS_BUS_CONTROL, 16'h0010);
      wait_clr(OFS_BUS_CONTROL, 16'h0010);
      d = {15'h0000, last_bit};
      chk(16'h0001, 16'h0000);
      rd_reg(OFS_RX_HOLDING);
      chk(16'hFFFF, 16'h00C3);
      rd_reg(OFS_BUS_STATUS);
      chk(16'h0002, 16'h0000);
      wr_reg(OFS_BUS_CONTROL, 16'h0002);
      wait_clr(OFS_BUS_CONTROL, 16'h0002);
      wr_reg(OFS_BUS_CONTROL, 16'h0004);
      wait_clr(OFS_BUS_CONTROL, 16'h0004);
      rd_reg(OFS_BUS_STATUS);
      chk(16'h0018, 16'h0010);
      d = rx_cnt;
      chk(16'hFFFF, 16'h0002);
      d = gc_cnt;
      chk(16'hFFFF, 16'h0000);
      end_of_test();
   end
endmodule : tb_i2c_master_slave_status_ctrl
`default_nettype wire
